// ===== dv/apr_host_model.sv
// Host side model: one Wishbone classic transfer per go request
`timescale 1ns/1ps
`default_nettype none

module apr_host_model (
	input wire logic i_clk, // Clock
	input wire logic i_resetn, // Synchronous reset, active low
	input wire logic i_go, // Start one transfer
	input wire logic i_we, // Direction of the transfer
	input wire logic [7:0] i_adr, // Byte address
	input wire logic [7:0] i_dat, // Write byte
	output logic o_done, // Transfer finished
	output logic [7:0] o_rdat, // Read byte
	output logic o_cyc, // Wishbone cycle
	output logic o_stb, // Wishbone strobe
	output logic o_we, // Wishbone write enable
	output logic [7:0] o_adr, // Wishbone address
	output logic [3:0] o_sel, // Wishbone byte select
	output logic [31:0] o_dat, // Wishbone write data
	input wire logic i_ack, // Wishbone acknowledge
	input wire logic [31:0] i_wb_dat // Wishbone read data
);
	always_ff @(posedge i_clk) begin
		o_done <= 1'b0;
		o_sel <= 4'h1;
		if (!i_resetn) begin
			o_cyc <= 1'b0;
			o_stb <= 1'b0;
		end else if (o_cyc && i_ack) begin
			// Waits however long the device stalls slow writes
			o_cyc <= 1'b0;
			o_stb <= 1'b0;
			o_rdat <= i_wb_dat[7:0];
			o_adr <= ~o_adr;
			o_dat <= ~o_dat;
			o_done <= 1'b1;
		end else if (!o_cyc && i_go) begin
			// Issues only the requests it is given, bench also writes illegal power codes
			o_cyc <= 1'b1;
			o_stb <= 1'b1;
			o_we <= i_we;
			o_adr <= i_adr;
			o_dat <= {24'h000000, i_dat};
		end
	end
endmodule // apr_host_model

`default_nettype wire

// ===== dv/apr_top_bench.sv
// Register level testbench of the range and power config block
`timescale 1ns/1ps
`default_nettype none
`include "apr_defines.svh"

module apr_top_bench;
	logic clk, rst_n, go, we, push, pop, meas, done, cyc, stb, wwe, ack, irq, fifo_acc;
	logic variant, equi, tick;
	logic [7:0] adr, wdat, rdat, wadr;
	logic [3:0] sel, cut_idx;
	logic [31:0] wdo, wdi;
	logic [2:0] pstate;
	logic [1:0] grange;
	int error_cnt, tests_run, last_n, cyc_cnt, k, n;
	logic [7:0] gs [4] = '{8'h03, 8'h05, 8'h08, 8'h0c};
	logic [7:0] pw [7] = '{8'h00, 8'h40, 8'h80, 8'h60, 8'he0, 8'ha0, 8'hc0};
	logic [2:0] pe [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h4};

	apr_host_model host_u (.i_clk(clk), .i_resetn(rst_n), .i_go(go), .i_we(we), .i_adr(adr),
		.i_dat(wdat), .o_done(done), .o_rdat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(wwe),
		.o_adr(wadr), .o_sel(sel), .o_dat(wdo), .i_ack(ack), .i_wb_dat(wdi));

	apr_top #(.HALF_MS_CYC(4), .FIFO_DEPTH(7'd4)) dut_u (.I_REF_CLK(clk), .I_RESETN(rst_n),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(wwe), .I_WB_ADR(wadr), .I_WB_SEL(sel),
		.I_WB_DAT(wdo), .O_WB_ACK(ack), .O_WB_DAT(wdi), .I_FRAME_PUSH(push),
		.I_FRAME_POP(pop), .I_MEAS_DONE(meas), .O_IRQ(irq), .O_POWER_STATE(pstate),
		.O_GRANGE(grange), .O_CUTOFF_IDX(cut_idx), .O_DOZE_VARIANT(variant),
		.O_FIFO_ACCESS(fifo_acc), .O_EQUIDISTANT(equi), .O_SAMPLE_TICK(tick));

	always #50 clk = ~clk;

	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d);
		go <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= d;
		@(posedge clk);
		go <= 1'b0;
		last_n = 0;
		do begin
			@(posedge clk);
			last_n++;
		end while (done !== 1'b1 && last_n < 100);
		chk("ack", 8'h01, {7'h00, done});
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] e, input string nm);
		xfer(1'b0, idx, 8'h00);
		chk(nm, e, rdat);
	endtask

	// Source 0 pops, 1 pushes, 2 ends a measurement; held for c cycles
	task automatic strobe(input int s, input int c);
		push <= (s == 1);
		pop <= (s == 0);
		meas <= (s == 2);
		repeat (c) @(posedge clk);
		push <= 1'b0;
		pop <= 1'b0;
		meas <= 1'b0;
	endtask

	task automatic tick_gap(output int f, output int g);
		f = 0;
		while (tick !== 1'b1 && f < 300) begin
			@(posedge clk);
			f++;
		end
		g = 0;
		do begin
			@(posedge clk);
			g++;
		end while (tick !== 1'b1 && g < 300);
	endtask

	task automatic conclude();
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		clk = 0; rst_n = 0; go = 0; we = 0; adr = 0; wdat = 0;
		push = 0; pop = 0; meas = 0; error_cnt = 0; tests_run = 0; cyc_cnt = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(`APR_IDX_GSCALE, `APR_GSCALE_RST, "gscale");
		chk("cutoff_rst", 8'h07, {4'h0, cut_idx});
		rd(`APR_IDX_CUTOFF, `APR_CUTOFF_RST, "cutoff");
		rd(`APR_IDX_POWER, 8'h00, "power");
		rd(`APR_IDX_DOZE, 8'h00, "doze");
		rd(6'h3f, 8'h00, "unmapped");
		strobe(1, 3);
		rd(`APR_IDX_FIFO_STAT, 8'h03, "frames");
		xfer(1'b1, `APR_IDX_FIFO_STAT, 8'hff);
		rd(`APR_IDX_FIFO_STAT, 8'h03, "status_ro");
		strobe(0, 3);
		rd(`APR_IDX_FIFO_STAT, 8'h00, "drained");
		strobe(1, 5);
		rd(`APR_IDX_FIFO_STAT, 8'h84, "overrun");
		chk("irq_masked", 8'h00, {7'h00, irq});
		xfer(1'b1, `APR_IDX_IRQ_MASK, 8'h01);
		chk("irq_set", 8'h01, {7'h00, irq});
		rd(`APR_IDX_IRQ_STAT, 8'h03, "irq_stat");
		chk("irq_clear", 8'h00, {7'h00, irq});
		rd(`APR_IDX_FIFO_STAT, 8'h84, "sticky");
		xfer(1'b1, `APR_IDX_FIFO_CLR, 8'h00);
		rd(`APR_IDX_FIFO_STAT, 8'h00, "cleared");
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `APR_IDX_GSCALE, gs[i]);
			chk("grange", 8'(i), {6'h00, grange});
		end
		xfer(1'b1, `APR_IDX_GSCALE, 8'h05);
		chk("grange_down", 8'h01, {6'h00, grange});
		for (int i = 0; i < 12; i++) begin
			xfer(1'b1, `APR_IDX_CUTOFF, 8'(8'h06 + i));
			chk("cutoff_idx", 8'((i < 3) ? 0 : ((i > 9) ? 7 : i - 2)), {4'h0, cut_idx});
		end
		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, `APR_IDX_POWER, pw[i]);
			chk("pstate", {5'h00, pe[i]}, {5'h00, pstate});
		end
		rd(`APR_IDX_IRQ_STAT, 8'h0c, "irq_events");
		xfer(1'b1, `APR_IDX_POWER, 8'h20);
		chk("pstate_deep", 8'h01, {5'h00, pstate});
		rd(`APR_IDX_GSCALE, `APR_GSCALE_RST, "gscale_deep");
		xfer(1'b1, `APR_IDX_POWER, 8'h80);
		chk("fifo_closed", 8'h00, {7'h00, fifo_acc});
		xfer(1'b1, `APR_IDX_DOZE, 8'h00);
		chk("slow_wr", 8'h01, {7'h00, last_n >= 21});
		strobe(1, 1);
		strobe(0, 1);
		rd(`APR_IDX_FIFO_STAT, 8'h01, "pop_blocked");
		xfer(1'b1, `APR_IDX_DOZE, 8'h40);
		chk("variant", 8'h01, {7'h00, variant});
		chk("fifo_open", 8'h01, {7'h00, fifo_acc});
		xfer(1'b1, `APR_IDX_DOZE, 8'h40);
		chk("fast_wr", 8'h01, {7'h00, last_n < 21});
		strobe(0, 1);
		rd(`APR_IDX_FIFO_STAT, 8'h00, "pop_open");
		xfer(1'b1, `APR_IDX_DOZE, 8'h60);
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, `APR_IDX_POWER, 8'h40 | 8'((i == 0) ? 0 : ((i == 1) ? 6 : 9)));
			chk("equi", 8'h01, {7'h00, equi});
			tick_gap(k, n);
			tick_gap(k, n);
			chk("sleep_len", 8'((i == 0) ? 4 : ((i == 1) ? 8 : 48)), 8'(n));
		end
		xfer(1'b1, `APR_IDX_DOZE, 8'h40);
		xfer(1'b1, `APR_IDX_POWER, 8'h40);
		chk("event_mode", 8'h00, {7'h00, equi});
		strobe(2, 1);
		tick_gap(k, n);
		chk("held", 8'h01, {7'h00, n >= 300});
		strobe(2, 1);
		tick_gap(k, n);
		chk("resumed", 8'h01, {7'h00, k < 20});
		xfer(1'b1, `APR_IDX_POWER, 8'h00);
		conclude();
	end
endmodule // apr_top_bench

`default_nettype wire

// ===== rtl/apr_defines.svh
// Offsets, field positions, reset values and timing counts of the range and power config block
`ifndef APR_DEFINES_SVH
`define APR_DEFINES_SVH

// Register indices; byte address is four times the index
`define APR_IDX_FIFO_STAT 6'h0e
`define APR_IDX_GSCALE 6'h0f
`define APR_IDX_CUTOFF 6'h10
`define APR_IDX_POWER 6'h11
`define APR_IDX_DOZE 6'h12
`define APR_IDX_FIFO_CLR 6'h20
`define APR_IDX_IRQ_STAT 6'h21
`define APR_IDX_IRQ_MASK 6'h22

// Reset values and writable bits
`define APR_GSCALE_RST 8'h03
`define APR_CUTOFF_RST 8'h0f
`define APR_POWER_RST 8'h00
`define APR_DOZE_RST 8'h00
`define APR_GSCALE_MASK 8'h0f
`define APR_CUTOFF_MASK 8'h1f
`define APR_POWER_MASK 8'hff
`define APR_DOZE_MASK 8'h60

// Field positions
`define APR_OVR_BIT 7
`define APR_VARIANT_BIT 6
`define APR_TIMEBASE_BIT 5
`define APR_PWR_DEEP_CODE 3'b001

// G-scale codes
`define APR_GS_2G 4'h3
`define APR_GS_4G 4'h5
`define APR_GS_8G 4'h8
`define APR_GS_16G 4'hc

// Interrupt status bits
`define APR_EV_OVERRUN 0
`define APR_EV_FRAME 1
`define APR_EV_WAKE 2
`define APR_EV_ILLEGAL 3

// Timing
`define APR_FIFO_DEPTH 32
`define APR_CLK_PERIOD_NS 100
`define APR_SLEEP_UNIT_NS 500000
`define APR_SLEEP_UNIT_CYC (`APR_SLEEP_UNIT_NS / `APR_CLK_PERIOD_NS)
`define APR_SLOW_WR_NS 2000
`define APR_SLOW_WR_CYC ((`APR_SLOW_WR_NS + `APR_CLK_PERIOD_NS - 1) / `APR_CLK_PERIOD_NS)

`endif

// ===== rtl/apr_doze_timer.sv
// Sleep phase timer of the duty-cycled power state
`timescale 1ns/1ps
`default_nettype none
`include "apr_defines.svh"

module apr_doze_timer
	import apr_pkg::*;
#(
	parameter int UNIT_CYC = `APR_SLEEP_UNIT_CYC
) (
	input wire logic i_clk, // Clock
	input wire logic i_resetn, // Synchronous reset, active low
	input wire logic i_run, // Duty-cycled state active
	input wire logic i_equi, // Equidistant time-base selected
	input wire logic i_meas_done, // Active phase finished
	input wire logic [3:0] i_code, // Sleep length code
	output logic o_tick // Wake pulse
);

	apr_timer_t r;
	apr_timer_t n;

	// Sleep length in cycles, in units of half a millisecond
	function automatic logic [23:0] sleep_cycles(input logic [3:0] code);
		logic [11:0] units;
		units = 12'h001;
		case (code)
			4'h6: units = 12'h002;
			4'h7: units = 12'h004;
			4'h8: units = 12'h008;
			4'h9: units = 12'h00c;
			4'ha: units = 12'h014;
			4'hb: units = 12'h032;
			4'hc: units = 12'h064;
			4'hd: units = 12'h0c8;
			4'he: units = 12'h3e8;
			4'hf: units = 12'h7d0;
			default: units = 12'h001;
		endcase
		sleep_cycles = 24'(units * UNIT_CYC);
	endfunction

	always_comb begin
		n = r;
		n.tick = 1'b0;
		if (!i_run) begin
			n.cnt = 24'h000000;
			n.waiting = 1'b0;
		end else if (r.waiting) begin
			// Event-driven: next sleep starts once the active phase ends
			if (i_meas_done) begin // R13
				n.waiting = 1'b0;
				n.cnt = 24'h000000;
			end
		end else if (r.cnt >= sleep_cycles(i_code) - 24'h000001) begin // R08
			n.tick = 1'b1;
			n.cnt = 24'h000000;
			n.waiting = !i_equi; // R14
		end else begin
			n.cnt = r.cnt + 24'h000001;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_tick = r.tick;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	property p_event_wait;
		(i_run && r.waiting && !i_meas_done) |=> !r.tick;
	endproperty
	a_event_wait: assert property (p_event_wait) else $error("tick during event wait"); // R13

	property p_equi_free;
		(i_run && i_equi && !r.waiting) |=> !r.waiting;
	endproperty
	a_equi_free: assert property (p_equi_free) else $error("equidistant timer stalled"); // R14

	c_tick: cover property (i_run && r.tick);

endmodule // apr_doze_timer

`default_nettype wire

// ===== rtl/apr_pkg.sv
// Types of the range and power config block
package apr_pkg;

	typedef enum logic [2:0] {
		APR_PWR_RUN,
		APR_PWR_DEEP,
		APR_PWR_DUTY,
		APR_PWR_HALT,
		APR_PWR_ILLEGAL
	} apr_pwr_t;

	typedef enum logic [1:0] {APR_G2, APR_G4, APR_G8, APR_G16} apr_grange_t;

	typedef enum logic [1:0] {APR_BUS_IDLE, APR_BUS_WAIT, APR_BUS_ACK} apr_bus_t;

	typedef struct packed {
		logic [7:0] gscale;
		logic [7:0] cutoff;
		logic [7:0] power;
		logic [7:0] doze;
		logic overrun;
		logic [6:0] frames;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic irq;
		apr_bus_t bus;
		logic [7:0] wait_cnt;
		logic ack;
		logic [31:0] rdat;
		apr_pwr_t pwr;
		apr_grange_t grange;
		logic [3:0] cutoff_idx;
		logic fifo_open;
		logic equi;
	} apr_state_t;

	typedef struct packed {
		logic [23:0] cnt;
		logic waiting;
		logic tick;
	} apr_timer_t;

endpackage

// ===== rtl/apr_top.sv
// Range, filter and power configuration registers with FIFO fill status
//
// Behaviour
// (R01) Overrun flag sticky until FIFO config write
// (R02) Seven-bit frame count, zero when empty
// (R03) Count clears on full readout or config write
// (R04) G-scale codes 3,5,8,c select 2/4/8/16g
// (R05) Cutoff code maps 7.81 Hz up to 1000 Hz
// (R06) Three power bits decode run/deep/duty/halt/illegal
// (R07) Host requests only permitted power transitions; the bench also writes illegal codes, which raise APR_EV_ILLEGAL
// (R08) Four-bit code sets duty-cycle sleep length
// (R09) Host reprograms settings after deepest sleep
// (R10) Variant bit picks first or second variant
// (R11) First variant: FIFO closed, writes slowed
// (R12) Second variant: FIFO open, full-speed writes
// (R13) Time-base bit picks event or equidistant timing
// (R14) Even sample spacing only with equidistant time-base
// (R15) Writes to FIFO status register are ignored
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "apr_defines.svh"

module apr_top
	import apr_pkg::*;
#(
	parameter int HALF_MS_CYC = `APR_SLEEP_UNIT_CYC,
	parameter logic [6:0] FIFO_DEPTH = 7'(`APR_FIFO_DEPTH)
) (
	input wire logic I_REF_CLK, // 10 MHz clock
	input wire logic I_RESETN, // Synchronous reset, active low
	input wire logic I_WB_CYC, // Wishbone cycle
	input wire logic I_WB_STB, // Wishbone strobe
	input wire logic I_WB_WE, // Wishbone write enable
	input wire logic [7:0] I_WB_ADR, // Wishbone byte address
	input wire logic [3:0] I_WB_SEL, // Wishbone byte select
	input wire logic [31:0] I_WB_DAT, // Wishbone write data
	output logic O_WB_ACK, // Wishbone acknowledge
	output logic [31:0] O_WB_DAT, // Wishbone read data
	input wire logic I_FRAME_PUSH, // A frame enters the FIFO
	input wire logic I_FRAME_POP, // Host reads one frame out
	input wire logic I_MEAS_DONE, // Active measurement phase over
	output logic O_IRQ, // Level interrupt
	output logic [2:0] O_POWER_STATE, // Decoded power state
	output logic [1:0] O_GRANGE, // Selected g-range
	output logic [3:0] O_CUTOFF_IDX, // 0: 7.81 Hz .. 7: 1000 Hz
	output logic O_DOZE_VARIANT, // 0 first, 1 second variant
	output logic O_FIFO_ACCESS, // FIFO reachable by host
	output logic O_EQUIDISTANT, // Duty state on equidistant time-base
	output logic O_SAMPLE_TICK // Wake pulse of duty-cycled state
);

	apr_state_t r;
	apr_state_t n;
	logic do_acc;
	logic acc_wr;
	logic fifo_clr;
	logic stat_clr;
	logic ev_illegal;
	logic pop_ok;
	logic ovf;
	logic wake_tick;
	logic [3:0] events;
	logic [5:0] idx;
	logic [7:0] wdat;

	function automatic apr_pwr_t pwr_dec(input logic [2:0] bits);
		case (bits)
			3'b000: pwr_dec = APR_PWR_RUN;
			3'b001: pwr_dec = APR_PWR_DEEP;
			3'b010: pwr_dec = APR_PWR_DUTY;
			3'b100: pwr_dec = APR_PWR_HALT;
			default: pwr_dec = APR_PWR_ILLEGAL;
		endcase
	endfunction

	// Reserved codes keep the range in force
	function automatic apr_grange_t grange_dec(input logic [3:0] code, input apr_grange_t cur);
		case (code)
			`APR_GS_2G: grange_dec = APR_G2;
			`APR_GS_4G: grange_dec = APR_G4;
			`APR_GS_8G: grange_dec = APR_G8;
			`APR_GS_16G: grange_dec = APR_G16;
			default: grange_dec = cur;
		endcase
	endfunction

	function automatic logic [3:0] cutoff_dec(input logic [4:0] code);
		if (code[4] || code == 5'h0f) begin
			cutoff_dec = 4'h7;
		end else if (code <= 5'h08) begin
			cutoff_dec = 4'h0;
		end else begin
			cutoff_dec = code[3:0] - 4'h8;
		end
	endfunction

	function automatic logic [7:0] rd_byte(input logic [5:0] a, input apr_state_t s);
		case (a)
			`APR_IDX_FIFO_STAT: rd_byte = {s.overrun, s.frames};
			`APR_IDX_GSCALE: rd_byte = s.gscale;
			`APR_IDX_CUTOFF: rd_byte = s.cutoff;
			`APR_IDX_POWER: rd_byte = s.power;
			`APR_IDX_DOZE: rd_byte = s.doze;
			`APR_IDX_IRQ_STAT: rd_byte = {4'h0, s.irq_stat};
			`APR_IDX_IRQ_MASK: rd_byte = {4'h0, s.irq_mask};
			default: rd_byte = 8'h00;
		endcase
	endfunction

	apr_doze_timer #(
		.UNIT_CYC(HALF_MS_CYC)
	) u_timer (
		.i_clk(I_REF_CLK),
		.i_resetn(I_RESETN),
		.i_run(r.pwr == APR_PWR_DUTY),
		.i_equi(r.doze[`APR_TIMEBASE_BIT]),
		.i_meas_done(I_MEAS_DONE),
		.i_code(r.power[3:0]),
		.o_tick(wake_tick)
	);

	assign idx = I_WB_ADR[7:2];
	assign wdat = I_WB_DAT[7:0];

	always_comb begin
		n = r;
		n.ack = 1'b0;
		do_acc = 1'b0;
		case (r.bus)
			APR_BUS_IDLE: begin
				if (I_WB_CYC && I_WB_STB) begin
					if (I_WB_WE && !r.fifo_open) begin // R11
						n.bus = APR_BUS_WAIT;
						n.wait_cnt = 8'(`APR_SLOW_WR_CYC - 1);
					end else begin
						do_acc = 1'b1; // R12
					end
				end
			end
			APR_BUS_WAIT: begin
				if (r.wait_cnt == 8'h00) begin
					do_acc = 1'b1;
				end else begin
					n.wait_cnt = r.wait_cnt - 8'h01;
				end
			end
			APR_BUS_ACK: n.bus = APR_BUS_IDLE;
			default: n.bus = APR_BUS_IDLE;
		endcase
		if (do_acc) begin
			n.ack = 1'b1;
			n.bus = APR_BUS_ACK;
			n.rdat = {24'h000000, rd_byte(idx, r)};
		end
		acc_wr = do_acc && I_WB_WE && I_WB_SEL[0];
		stat_clr = do_acc && !I_WB_WE && idx == `APR_IDX_IRQ_STAT;
		fifo_clr = 1'b0;
		ev_illegal = 1'b0;

		if (acc_wr) begin
			case (idx)
				`APR_IDX_GSCALE: n.gscale = wdat & `APR_GSCALE_MASK;
				`APR_IDX_CUTOFF: n.cutoff = wdat & `APR_CUTOFF_MASK;
				`APR_IDX_DOZE: n.doze = wdat & `APR_DOZE_MASK;
				`APR_IDX_POWER: begin
					n.power = wdat & `APR_POWER_MASK;
					ev_illegal = pwr_dec(wdat[7:5]) == APR_PWR_ILLEGAL;
					// Deepest sleep loses the configuration
					if (wdat[7:5] == `APR_PWR_DEEP_CODE) begin
						n.gscale = `APR_GSCALE_RST;
						n.cutoff = `APR_CUTOFF_RST;
						n.doze = `APR_DOZE_RST;
					end
				end
				`APR_IDX_FIFO_CLR: fifo_clr = 1'b1;
				`APR_IDX_IRQ_MASK: n.irq_mask = wdat[3:0];
				default: ; // R15
			endcase
		end

		// Frame accounting
		pop_ok = I_FRAME_POP && r.fifo_open && r.frames != 7'h00; // R11
		ovf = I_FRAME_PUSH && !pop_ok && r.frames >= FIFO_DEPTH;
		n.overrun = (r.overrun && !fifo_clr) || ovf; // R01
		if (fifo_clr) begin
			n.frames = I_FRAME_PUSH ? 7'h01 : 7'h00; // R03
		end else if (I_FRAME_PUSH && !pop_ok && !ovf) begin
			n.frames = r.frames + 7'h01; // R02
		end else if (pop_ok && !I_FRAME_PUSH) begin
			n.frames = r.frames - 7'h01; // R03
		end

		events = 4'h0;
		events[`APR_EV_OVERRUN] = ovf;
		events[`APR_EV_FRAME] = I_FRAME_PUSH;
		events[`APR_EV_WAKE] = wake_tick;
		events[`APR_EV_ILLEGAL] = ev_illegal;
		n.irq_stat = (r.irq_stat & ~{4{stat_clr}}) | events;
		n.irq = |(n.irq_stat & n.irq_mask);

		n.pwr = pwr_dec(n.power[7:5]); // R06
		n.grange = grange_dec(n.gscale[3:0], r.grange); // R04
		n.cutoff_idx = cutoff_dec(n.cutoff[4:0]); // R05
		n.fifo_open = n.doze[`APR_VARIANT_BIT] ||
			!(n.pwr == APR_PWR_HALT || n.pwr == APR_PWR_DUTY); // R10
		n.equi = n.pwr == APR_PWR_DUTY && n.doze[`APR_TIMEBASE_BIT]; // R13
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			r <= '0;
			r.gscale <= `APR_GSCALE_RST;
			r.cutoff <= `APR_CUTOFF_RST;
			r.power <= `APR_POWER_RST;
			r.doze <= `APR_DOZE_RST;
			r.cutoff_idx <= 4'h7;
			r.fifo_open <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign O_WB_ACK = r.ack;
	assign O_WB_DAT = r.rdat;
	assign O_IRQ = r.irq;
	assign O_POWER_STATE = r.pwr;
	assign O_GRANGE = r.grange;
	assign O_CUTOFF_IDX = r.cutoff_idx;
	assign O_DOZE_VARIANT = r.doze[`APR_VARIANT_BIT];
	assign O_FIFO_ACCESS = r.fifo_open;
	assign O_EQUIDISTANT = r.equi;
	assign O_SAMPLE_TICK = wake_tick;

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RESETN);

	property p_ovr_sticky;
		(r.overrun && !(acc_wr && idx == `APR_IDX_FIFO_CLR)) |=> r.overrun;
	endproperty
	a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost"); // R01

	property p_frame_inc;
		(I_FRAME_PUSH && !I_FRAME_POP && r.frames < FIFO_DEPTH && !fifo_clr)
			|=> r.frames == $past(r.frames) + 7'h01;
	endproperty
	a_frame_inc: assert property (p_frame_inc) else $error("frame count missed push"); // R02

	property p_clr;
		(fifo_clr && !I_FRAME_PUSH) |=> (r.frames == 7'h00 && !r.overrun);
	endproperty
	a_clr: assert property (p_clr) else $error("config write did not clear"); // R03

	property p_g16;
		r.gscale[3:0] == `APR_GS_16G |-> r.grange == APR_G16;
	endproperty
	a_g16: assert property (p_g16) else $error("16g code not applied"); // R04

	property p_cut_top;
		r.cutoff[4] |-> r.cutoff_idx == 4'h7;
	endproperty
	a_cut_top: assert property (p_cut_top) else $error("high cutoff code wrong"); // R05

	property p_duty;
		r.power[7:5] == 3'b010 |-> (r.pwr == APR_PWR_DUTY && O_POWER_STATE == 3'(APR_PWR_DUTY));
	endproperty
	a_duty: assert property (p_duty) else $error("duty state not decoded"); // R06

	property p_variant;
		(!r.doze[`APR_VARIANT_BIT] && r.pwr == APR_PWR_HALT) |-> !O_FIFO_ACCESS;
	endproperty
	a_variant: assert property (p_variant) else $error("FIFO open in first variant"); // R10

	property p_slow_wr;
		(r.bus == APR_BUS_IDLE && I_WB_CYC && I_WB_STB && I_WB_WE && !r.fifo_open)
			|=> !r.ack [*8];
	endproperty
	a_slow_wr: assert property (p_slow_wr) else $error("write not slowed"); // R11

	property p_fast_wr;
		(r.bus == APR_BUS_IDLE && I_WB_CYC && I_WB_STB && r.fifo_open) |=> r.ack;
	endproperty
	a_fast_wr: assert property (p_fast_wr) else $error("full-speed access late"); // R12

	property p_stat_ro;
		(acc_wr && idx == `APR_IDX_FIFO_STAT && !I_FRAME_PUSH && !I_FRAME_POP)
			|=> ($stable(r.frames) && $stable(r.overrun));
	endproperty
	a_stat_ro: assert property (p_stat_ro) else $error("status write took effect"); // R15

	property p_pop_blocked;
		(I_FRAME_POP && !I_FRAME_PUSH && !r.fifo_open && !fifo_clr) |=> $stable(r.frames);
	endproperty
	a_pop_blocked: assert property (p_pop_blocked) else $error("pop while FIFO closed"); // R11

	property p_drain;
		(pop_ok && !I_FRAME_PUSH && !fifo_clr && r.frames == 7'h01) |=> r.frames == 7'h00;
	endproperty
	a_drain: assert property (p_drain) else $error("last pop left frames"); // R03

	property p_equi_out;
		(r.pwr == APR_PWR_DUTY) |-> (O_EQUIDISTANT == r.doze[`APR_TIMEBASE_BIT]);
	endproperty
	a_equi_out: assert property (p_equi_out) else $error("time-base select not applied"); // R13

	c_overrun: cover property (ovf);
	c_slow_ack: cover property (r.bus == APR_BUS_WAIT ##[1:40] r.ack);
	c_irq: cover property (r.irq && stat_clr);

endmodule // apr_top

`default_nettype wire
